// ===== design/line_locked_clock_generator.sv
// Top of the line-locked clock generator: reference selection, period
// tracking, oscillator, register port, divider and reset sequencer.
// Assumes all pin inputs are synchronous to CORE_CLK and one AHB-Lite master.
`timescale 1ns/10ps
module line_locked_clock_generator
  import llcg_pkg::*;
#(
  parameter int RESET_DELAY_CYCLES = RST_DELAY_MIN_CYC // Shorten in simulation
) (
  input wire logic CORE_CLK, // 50 MHz core clock
  input wire logic NRST, // Synchronous reset, active low
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic [31:0] HRDATA, // AHB read data
  output logic HREADYOUT, // AHB slave ready
  output logic HRESP, // AHB response
  input wire logic VCO_MODE_SEL, // High: free oscillator
  input wire logic REF_SOURCE_SEL, // High: reference B
  input wire logic LINE_FREQ_REF_A, // Primary reference
  input wire logic LINE_FREQ_REF_B, // Secondary reference
  input wire logic CHIP_ENABLE, // Chip enable
  input wire logic SUPPLY_FAIL, // Supply below threshold
  output logic CLK4X_A, // Fast clock A
  output logic CLK4X_B, // Fast clock B
  output logic CLK2X_A, // Half-rate clock A
  output logic CLK2X_B, // Half-rate clock B
  output logic CLK_QUALIFIER, // Clock qualifier
  output logic SYSTEM_RESET_OUT_N // System reset, active low
);
  typedef struct packed {
    logic ref_prev;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] meas;
    logic locked;
    logic [PER_W-1:0] phase;
    logic fast;
    logic [DLY_W-1:0] dly;
    logic [PER_W-1:0] vco_half;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } top_s;
  top_s s_q, s_d;

  logic ref_sel;
  logic ref_rise;
  logic [PER_W-1:0] half_per;
  logic tick;
  logic rise_tick;
  logic unmask;
  logic clk4x;
  logic clk2x;
  logic addr_ok;
  logic [31:0] rd_mux;

  // Register read decode, shared by the read path
  function automatic logic [31:0] read_reg(input logic [7:0] ofs, input top_s s, input logic rst_out);
    logic [31:0] v;
    v = 32'h00000000;
    case (ofs)
      OFS_RST_DELAY: v = {{(32-DLY_W){1'b0}}, s.dly};
      OFS_VCO_HALF: v = {{(32-PER_W){1'b0}}, s.vco_half};
      OFS_STATUS: begin
        v[ST_LOCKED] = s.locked;
        v[ST_RST_OUT] = rst_out;
        v[ST_VCO_MODE] = VCO_MODE_SEL;
        v[ST_SRC_B] = REF_SOURCE_SEL;
      end
      OFS_PERIOD: v = {{(32-PER_W){1'b0}}, s.meas};
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  assign ref_sel = REF_SOURCE_SEL ? LINE_FREQ_REF_B : LINE_FREQ_REF_A;
  assign ref_rise = ref_sel && !s_q.ref_prev;

  // oscillator half period from register or measurement
  // measured period split into eight equal half periods
  always_comb begin
    if (VCO_MODE_SEL) begin
      half_per = s_q.vco_half;
    end else begin
      half_per = s_q.meas >> HALF_SHIFT;
    end
    if (half_per == '0) begin
      half_per = 16'h0001;
    end
  end

  // equal high and low phases from one count
  assign tick = (s_q.phase == half_per - 16'h0001);
  assign rise_tick = tick && !s_q.fast;
  assign addr_ok = HSEL && HTRANS[HTRANS_ACT] && HREADY;
  assign rd_mux = read_reg(HADDR[7:0], s_q, unmask);

  // Next state of tracking, oscillator and register port
  always_comb begin
    s_d = s_q;
    s_d.ref_prev = ref_sel;
    // Period measurement, saturating when the reference stops
    if (ref_rise) begin
      s_d.per_cnt = 16'h0001;
      s_d.meas = s_q.per_cnt;
      s_d.locked = (s_q.per_cnt == s_q.meas) && (s_q.per_cnt != '1);
    end else if (s_q.per_cnt != '1) begin
      s_d.per_cnt = s_q.per_cnt + 1'b1;
    end else begin
      s_d.locked = 1'b0;
    end
    if (VCO_MODE_SEL) begin
      s_d.locked = 1'b1;
    end
    // Oscillator phase counter
    if (tick) begin
      s_d.phase = '0;
      s_d.fast = ~s_q.fast;
    end else if (s_q.phase > half_per - 16'h0001) begin
      // Half period shortened mid-count: restart the count, no toggle
      s_d.phase = '0;
    end else begin
      s_d.phase = s_q.phase + 1'b1;
    end
    // AHB address phase capture and read data
    if (HREADY) begin
      s_d.dp_wr = addr_ok && HWRITE;
      s_d.dp_addr = HADDR[7:0];
      s_d.rdata = (addr_ok && !HWRITE) ? rd_mux : 32'h00000000;
    end
    if (s_q.dp_wr) begin
      case (s_q.dp_addr)
        OFS_RST_DELAY: s_d.dly = HWDATA[DLY_W-1:0];
        OFS_VCO_HALF: s_d.vco_half = HWDATA[PER_W-1:0];
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      s_q <= '{ref_prev: 1'b0, per_cnt: '0, meas: '0, locked: 1'b0, phase: '0, fast: 1'b0,
               dly: DLY_W'(RESET_DELAY_CYCLES), vco_half: VCO_HALF_RST, dp_wr: 1'b0,
               dp_addr: 8'h00, rdata: 32'h00000000};
    end else begin
      s_q <= s_d;
    end
  end

  // release waits for a locked reference outside free oscillator mode, where locked is forced high
  reset_sequencer u_seq (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .chip_enable(CHIP_ENABLE),
    .supply_fail(SUPPLY_FAIL),
    .delay(s_q.dly),
    .locked(s_q.locked),
    .rise_tick(rise_tick),
    .unmask(unmask)
  );

  // clock division to 4x and 2x
  clock_divider u_div (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .tick(tick),
    .unmask(unmask),
    .clk4x_q(clk4x),
    .clk2x_q(clk2x),
    .rst_out_n_q(SYSTEM_RESET_OUT_N)
  );

  assign CLK4X_A = clk4x;
  assign CLK4X_B = clk4x;
  assign CLK2X_A = clk2x;
  assign CLK2X_B = clk2x;
  assign CLK_QUALIFIER = clk2x;
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Checks on the top level
  ce_low_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !CHIP_ENABLE ##1 !CHIP_ENABLE |=> !SYSTEM_RESET_OUT_N && CLK4X_A && CLK2X_B && CLK_QUALIFIER)
    else $error("enable low did not hold outputs");
  fail_reset_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    SUPPLY_FAIL |-> ##2 !SYSTEM_RESET_OUT_N) else $error("supply fail did not reset");
  src_measure_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (REF_SOURCE_SEL && $past(REF_SOURCE_SEL) && !$past(LINE_FREQ_REF_B) && LINE_FREQ_REF_B)
    |=> s_q.per_cnt == 16'h0001)
    else $error("reference B edge not used");
  half_count_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    tick |-> s_q.phase == half_per - 1'b1) else $error("unequal clock phase");
  vco_period_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (VCO_MODE_SEL && $stable(s_q.vco_half) && tick) |-> half_per == s_q.vco_half || s_q.vco_half == '0)
    else $error("free oscillator ignores setting");
  ratio_two_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    ($rose(CLK4X_A) && SYSTEM_RESET_OUT_N && $past(SYSTEM_RESET_OUT_N)) |-> $changed(CLK2X_A))
    else $error("2x clock not half of 4x");
  qual_rate_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CLK_QUALIFIER == CLK2X_A && CLK2X_B == CLK2X_A) else $error("qualifier off rate");
  release_edge_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $rose(SYSTEM_RESET_OUT_N) |-> CLK4X_A && CLK2X_A ##1 CLK4X_A) else $error("release off fast rise");
  release_cov: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(SYSTEM_RESET_OUT_N));
  vco_cov: cover property (@(posedge CORE_CLK) disable iff (!NRST) VCO_MODE_SEL && $rose(CLK4X_A));
  fail_cov: cover property (@(posedge CORE_CLK) disable iff (!NRST) SYSTEM_RESET_OUT_N && SUPPLY_FAIL);
endmodule

// ===== shared/llcg_pkg.sv
// Package for the line-locked clock generator.
// Assumes a single 50 MHz core clock and a 32-bit AHB-Lite register port.
package llcg_pkg;
  // Core clock rate
  localparam int CLK_MHZ = 50;
  // Reset interval limits, in milliseconds
  localparam int RST_DELAY_MIN_MS = 20;
  localparam int RST_DELAY_MAX_MS = 200;
  // Reset interval limits, in core cycles
  localparam int RST_DELAY_MIN_CYC = RST_DELAY_MIN_MS * CLK_MHZ * 1000;
  localparam int RST_DELAY_MAX_CYC = RST_DELAY_MAX_MS * CLK_MHZ * 1000;
  // Widths of the reset counter and the period counter
  localparam int DLY_W = 24;
  localparam int PER_W = 16;
  // Log2 of fast clock half periods per reference period (4x, 50 % duty)
  localparam int HALF_SHIFT = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_RST_DELAY = 8'h00;
  localparam logic [7:0] OFS_VCO_HALF = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  // Status field positions
  localparam int ST_LOCKED = 0;
  localparam int ST_RST_OUT = 1;
  localparam int ST_VCO_MODE = 2;
  localparam int ST_SRC_B = 3;
  // Reset value of the free-running oscillator half period
  localparam logic [PER_W-1:0] VCO_HALF_RST = 16'h0004;
  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACT = 1;
endpackage

// ===== design/clock_divider.sv
// Divider that turns the oscillator toggle ticks into the 4x and 2x clocks.
// Assumes the tick pulse comes from the main module on the core clock.
`timescale 1ns/10ps
module clock_divider
  import llcg_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic tick, // Toggle the fast clock
  input wire logic unmask, // Clocks may run
  output logic clk4x_q, // Masked fast clock
  output logic clk2x_q, // Masked half-rate clock
  output logic rst_out_n_q // Reset output, aligned with clocks
);
  typedef struct packed {
    logic fast;
    logic half;
    logic o4;
    logic o2;
    logic orst;
  } div_s;
  div_s s_q, s_d;

  // Next state of the divider chain
  always_comb begin
    s_d = s_q;
    if (tick) begin
      s_d.fast = ~s_q.fast;
    end
    // half rate toggles on fast rise
    if (tick && !s_q.fast) begin
      s_d.half = ~s_q.half;
    end
    // Parked so the first unmasked 2x rise meets a fast rise
    if (!unmask) begin
      s_d.half = tick && !s_q.fast;
    end
    s_d.o4 = unmask ? s_q.fast : 1'b1;
    s_d.o2 = unmask ? s_q.half : 1'b1;
    s_d.orst = unmask;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{fast: 1'b0, half: 1'b0, o4: 1'b1, o2: 1'b1, orst: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign clk4x_q = s_q.o4;
  assign clk2x_q = s_q.o2;
  assign rst_out_n_q = s_q.orst;

  // Checks on the divider
  mask_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rst_out_n_q |-> clk4x_q && clk2x_q) else $error("clocks low while reset out");
  edge_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(clk2x_q) |-> $rose(clk4x_q)) else $error("2x rise without 4x rise");
endmodule

// ===== design/reset_sequencer.sv
// Reset sequencer: holds the system reset and the clock mask.
// Assumes supply-fail and chip-enable inputs are synchronous to the core clock.
`timescale 1ns/10ps
module reset_sequencer
  import llcg_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous power-up reset, active low
  input wire logic chip_enable, // Chip enable level
  input wire logic supply_fail, // Supply below threshold
  input wire logic [DLY_W-1:0] delay, // Interval length in cycles
  input wire logic locked, // Oscillator locked
  input wire logic rise_tick, // Fast clock about to rise
  output logic unmask // Reset released, clocks running
);
  typedef enum logic [1:0] {HOLD, COUNT, WAIT_LOCK, RUN} seq_e;
  typedef struct packed {
    seq_e st;
    logic [DLY_W-1:0] cnt;
    logic ce;
  } seq_s;
  seq_s s_q, s_d;

  // Interval counting and release
  always_comb begin
    s_d = s_q;
    s_d.ce = chip_enable;
    case (s_q.st)
      HOLD: begin
        s_d.cnt = '0;
        if (chip_enable) begin
          s_d.st = COUNT;
        end
      end
      COUNT: begin
        if (s_q.cnt >= delay) begin
          s_d.st = WAIT_LOCK;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      WAIT_LOCK: begin
        // release on a fast clock rise
        if (locked && rise_tick) begin
          s_d.st = RUN;
        end
      end
      RUN: ;
      default: s_d.st = HOLD;
    endcase
    if (supply_fail && chip_enable) begin
      s_d.st = COUNT;
      s_d.cnt = '0;
    end
    if (!chip_enable) begin
      s_d.st = HOLD;
      s_d.cnt = '0;
    end
  end

  // State register; power-up starts an interval
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{st: COUNT, cnt: '0, ce: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // released only in the run state
  assign unmask = (s_q.st == RUN);

  interval_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(unmask) |-> $past(s_q.cnt) >= $past(delay)) else $error("reset released early");
endmodule

// ===== testbench/ref_source.sv
// Far-side model: the decoder side that feeds both line references.
// Assumes a 20 ns core clock; edges sit 5 ns off so they never meet a core edge.
`timescale 1ns/10ps
module ref_source #(
  parameter int HALF_A = 160, // Half period of reference A in ns
  parameter int HALF_B = 320 // Half period of reference B in ns
) (
  output logic ref_a, // Primary line reference
  output logic ref_b // Secondary line reference
);
  initial begin
    ref_a = 1'b0;
    #5;
    forever #(HALF_A) ref_a = ~ref_a;
  end
  initial begin
    ref_b = 1'b0;
    #5;
    forever #(HALF_B) ref_b = ~ref_b;
  end
endmodule

// ===== testbench/line_locked_clock_generator_test.sv
// Self-checking bench for the line-locked clock generator.
// Assumes the reference model drives both references from time zero.
`timescale 1ns/10ps
module line_locked_clock_generator_test import llcg_pkg::*;;
  localparam int DLY = 20;
  logic clk, core_rst_n, hsel, hwrite, mode, src, ce, fail, edge_ok, ah;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, d;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, ref_a, ref_b, c4a, c4b, c2a, c2b, cq, rst_out_n;
  wire logic [4:0] clks = {cq, c2b, c2a, c4b, c4a};
  int n_fail = 0;
  int samples_checked = 0;
  int per, hi, n;
  // Rows: mode, source, oscillator half period, expected fast period
  int rows [3][4] = '{'{0, 0, 4, 4}, '{0, 1, 4, 8}, '{1, 0, 3, 6}};

  ref_source #(.HALF_A(160), .HALF_B(320)) REF (.ref_a(ref_a), .ref_b(ref_b));
  line_locked_clock_generator #(.RESET_DELAY_CYCLES(DLY)) DUT (
    .CORE_CLK(clk), .NRST(core_rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .VCO_MODE_SEL(mode), .REF_SOURCE_SEL(src),
    .LINE_FREQ_REF_A(ref_a), .LINE_FREQ_REF_B(ref_b), .CHIP_ENABLE(ce), .SUPPLY_FAIL(fail),
    .CLK4X_A(c4a), .CLK4X_B(c4b), .CLK2X_A(c2a), .CLK2X_B(c2b), .CLK_QUALIFIER(cq),
    .SYSTEM_RESET_OUT_N(rst_out_n));

  // Core clock, 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // One single AHB-Lite transfer; hready is checked where it stands settled
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
    end
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
    end
    r = hrdata;
  endtask

  // Waits for the system reset to lift; notes whether clocks stayed high
  task automatic wait_release(output int k, output logic all_high);
    k = 0;
    all_high = 1'b1;
    while (rst_out_n !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
      all_high &= (clks === 5'h1F);
    end
    chk_bit(rst_out_n, 1'b1);
  endtask

  // Period and high time of one clock output; eo: fast clock rose with it
  task automatic meas(input int b, output int p_len, output int h_len, output logic eo);
    logic [4:0] p;
    int k;
    p_len = 0;
    h_len = 0;
    k = 0;
    @(negedge clk);
    p = clks;
    while (!(clks[b] === 1'b1 && p[b] === 1'b0) && k < 400) begin
      p = clks;
      @(negedge clk);
      k++;
    end
    eo = clks[0] & ~p[0];
    do begin
      p = clks;
      @(negedge clk);
      p_len++;
      h_len += int'(p[b] === 1'b1);
    end while (!(clks[b] === 1'b1 && p[b] === 1'b0) && p_len < 400);
  endtask

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    core_rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mode = 1'b0;
    src = 1'b0;
    ce = 1'b1;
    fail = 1'b0;
    repeat (3) @(negedge clk);
    chk_word({27'h0, clks}, 32'h1F);
    chk_bit(rst_out_n, 1'b0);
    @(posedge clk);
    core_rst_n <= 1'b1;
    ahb(1'b0, {24'h0, OFS_RST_DELAY}, 32'h0, d);
    chk_word(d, 32'(DLY));
    ahb(1'b0, {24'h0, OFS_VCO_HALF}, 32'h0, d);
    chk_word(d, 32'(VCO_HALF_RST));
    ahb(1'b1, 32'h30, 32'hFFFF, d);
    ahb(1'b0, 32'h30, 32'h0, d);
    chk_word(d, 32'h0);
    chk_bit(hresp, 1'b0);
    // Table of source and mode settings
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      mode <= rows[i][0][0];
      src <= rows[i][1][0];
      ahb(1'b1, {24'h0, OFS_VCO_HALF}, 32'(rows[i][2]), d);
      wait_release(n, ah);
      // Let the period tracker see several reference periods
      repeat (200) @(posedge clk);
      meas(0, per, hi, edge_ok);
      chk_word(32'(per), 32'(rows[i][3]));
      chk_word(32'(hi), 32'(rows[i][3] / 2));
      chk_bit(c4b, c4a);
      meas(2, per, hi, edge_ok);
      chk_word(32'(per), 32'(2 * rows[i][3]));
      chk_word(32'(hi), 32'(rows[i][3]));
      chk_bit(edge_ok, 1'b1);
      chk_bit(c2b, c2a);
      meas(4, per, hi, edge_ok);
      chk_word(32'(per), 32'(2 * rows[i][3]));
      ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0, d);
      chk_word(d, 32'(rows[i][1] * 8 + rows[i][0] * 4 + 3));
    end
    // Chip enable low, then a longer interval
    @(posedge clk);
    mode <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(rst_out_n, 1'b0);
    chk_word({27'h0, clks}, 32'h1F);
    ahb(1'b1, {24'h0, OFS_RST_DELAY}, 32'd30, d);
    ce <= 1'b1;
    wait_release(n, ah);
    chk_bit(n >= 30, 1'b1);
    chk_bit(ah, 1'b1);
    // Supply-fail pulse restarts the interval
    @(posedge clk);
    fail <= 1'b1;
    @(posedge clk);
    fail <= 1'b0;
    repeat (4) @(negedge clk);
    chk_bit(rst_out_n, 1'b0);
    chk_word({27'h0, clks}, 32'h1F);
    wait_release(n, ah);
    chk_bit(ah, 1'b1);
    give_verdict();
  end
endmodule
